// ### hdl/ddbp_array.sv
// Storage of four banks of one open row, with byte write enables
`timescale 1ns/100ps
module ddbp_array (
	// Clock
	input logic hclk,
	// Access bundle
	ddbp_mem_if.mem m
);
	logic [15:0] cells [0:4095];
	assign m.rd_data = cells[{m.rd_bank, m.rd_col}];
	always_ff @(posedge hclk)
	begin
		if (m.wr_en && m.wr_keep[0])
			cells[{m.wr_bank, m.wr_col}][7:0] <= m.wr_data[7:0];
		if (m.wr_en && m.wr_keep[1])
			cells[{m.wr_bank, m.wr_col}][15:8] <= m.wr_data[15:8];
	end
endmodule: ddbp_array

// ### hdl/ddbp_defs.svh
// Register offsets, field positions and reset values of the burst data path
`ifndef DDBP_DEFS_SVH
`define DDBP_DEFS_SVH
`define DDBP_MODE_OFS 8'h00
`define DDBP_EXT_OFS 8'h04
`define DDBP_STAT_OFS 8'h08
`define DDBP_BL_F 2:0
`define DDBP_BT_F 3
`define DDBP_CL_F 6:4
`define DDBP_AL_F 5:3
`define DDBP_BL4 3'h2
`define DDBP_BL8 3'h3
`define DDBP_BL_RST 3'h2
`define DDBP_BT_RST 1'h0
`define DDBP_CL_RST 3'h3
`define DDBP_AL_RST 3'h0
`define DDBP_CL_MIN 3'h3
`define DDBP_RD_LEAD 4'h2
`define DDBP_WR_LEAD 4'h3
`endif

// ### hdl/ddbp_mem_if.sv
// Array access bundle between the burst engines and the storage
`timescale 1ns/100ps
interface ddbp_mem_if;
	logic wr_en;
	logic [1:0] wr_bank;
	logic [9:0] wr_col;
	logic [15:0] wr_data;
	logic [1:0] wr_keep;
	logic [1:0] rd_bank;
	logic [9:0] rd_col;
	logic [15:0] rd_data;
	modport ctrl (output wr_en, wr_bank, wr_col, wr_data, wr_keep,
		rd_bank, rd_col, input rd_data);
	modport mem (input wr_en, wr_bank, wr_col, wr_data, wr_keep,
		rd_bank, rd_col, output rd_data);
endinterface: ddbp_mem_if

// ### hdl/ddbp_order.sv
// Column order within a burst group
`timescale 1ns/100ps
module ddbp_order (
	// Burst position
	input logic [2:0] start,
	input logic [2:0] beat,
	input logic interleave,
	// Ordered low column bits
	output logic [2:0] col
);
	always_comb
	begin
		if (interleave)
			col = start ^ beat;
		else
			col = {start[2] ^ beat[2], start[1:0] + beat[1:0]};
	end
endmodule: ddbp_order

// ### hdl/ddbp_pkg.sv
// Types shared by the burst data path modules
package ddbp_pkg;
	typedef struct packed {
		logic ck;
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [1:0] bank;
		logic [9:0] col;
		logic [15:0] dq;
		logic dqs;
		logic [1:0] mask;
	} ddbp_pins_type;
	typedef struct packed {
		logic vld;
		logic [1:0] bank;
		logic [9:0] col;
	} ddbp_entry_type;
	typedef struct packed {
		ddbp_entry_type cur;
		ddbp_entry_type nxt;
		logic [2:0] beat;
	} ddbp_burst_type;
	typedef enum logic [1:0] {
		ddbp_rd_idle = 2'b00,
		ddbp_rd_pre = 2'b01,
		ddbp_rd_data = 2'b11,
		ddbp_rd_post = 2'b10
	} ddbp_rd_state_type;
endpackage: ddbp_pkg

// ### hdl/ddbp_top.sv
// DDR2 burst data path: AHB mode registers, link sampling, burst engines
//
// Notes on behaviour
// - only burst lengths four and eight accepted
// - one bit picks sequential or interleaved order
// - length four orders by two low column bits
// - length eight sequential wraps within each nibble
// - length eight interleaved is start XOR beat
// - no burst stop command exists
// - read data starts read latency after command
// - cas latency in mode, additive in extended
// - strobe low one clock before read data
// - read beats edge aligned to strobe transitions
// - write latency is read latency minus one
// - capture four or eight beats, ignore rest
// - one write mask per byte, data timing
// - write mask ignored during reads
// - interruption may target any bank
// - timings use programmed burst length, not actual
// - burst stays inside its aligned column group
`timescale 1ns/100ps
`include "ddbp_defs.svh"
module ddbp_top #(
	parameter int PIPE_DEPTH = 16
) (
	// Clock and reset
	input logic hclk,
	input logic hresetn,
	// AHB-Lite slave
	input logic hsel,
	input logic [31:0] haddr,
	input logic [1:0] htrans,
	input logic hwrite,
	input logic [2:0] hsize,
	input logic [31:0] hwdata,
	input logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// Memory command pins
	input logic mem_ck,
	input logic cs_n,
	input logic ras_n,
	input logic cas_n,
	input logic we_n,
	input logic [1:0] bank,
	input logic [9:0] col_addr,
	// Memory data pins
	input logic [15:0] dq_in,
	output logic [15:0] dq_out,
	output logic dq_oe_n,
	input logic dqs_in,
	output logic dqs_out,
	output logic dqs_oe_n,
	input logic [1:0] write_byte_mask
);
	typedef struct packed {
		ddbp_pkg::ddbp_pins_type s1;
		ddbp_pkg::ddbp_pins_type s2;
		logic ck3;
		logic dqs3;
		logic [PIPE_DEPTH-1:0] pipe_rd;
		logic [PIPE_DEPTH-1:0] pipe_wr;
		ddbp_pkg::ddbp_entry_type [PIPE_DEPTH-1:0] pipe_e;
		logic [2:0] bl;
		logic bt;
		logic [2:0] cl;
		logic [2:0] al;
		logic [7:0] rd_cnt;
		logic [7:0] wr_cnt;
		logic ah_wr;
		logic [7:0] ah_addr;
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
		ddbp_pkg::ddbp_rd_state_type rd_state;
		ddbp_pkg::ddbp_burst_type rb;
		ddbp_pkg::ddbp_burst_type wb;
		logic [15:0] dq_out;
		logic dq_oe_n;
		logic dqs_out;
		logic dqs_oe_n;
	} ddbp_state_type;

	ddbp_state_type st;
	ddbp_state_type next_st;
	ddbp_pkg::ddbp_pins_type pins_raw;
	ddbp_pkg::ddbp_entry_type cmd_e;
	logic rise;
	logic fall;
	logic bl8;
	logic cmd_rd;
	logic cmd_wr;
	logic [3:0] rl;
	logic rd_arm;
	logic wr_arm;
	logic wcap;
	logic emit;
	logic [2:0] rd_low;
	logic [2:0] wr_low;

	ddbp_mem_if m ();

	ddbp_order u_rd_order (
		.start(st.rb.cur.col[2:0]),
		.beat(st.rb.beat),
		.interleave(st.bt),
		.col(rd_low)
	);
	ddbp_order u_wr_order (
		.start(st.wb.cur.col[2:0]),
		.beat(st.wb.beat),
		.interleave(st.bt),
		.col(wr_low)
	);
	ddbp_array u_array (
		.hclk(hclk),
		.m(m.mem)
	);

	// True when the current beat closes the burst; the end is taken from
	// the programmed length unless a follower cuts it short after beat three
	function automatic logic burst_end(input ddbp_pkg::ddbp_burst_type b,
		input logic len8);
		burst_end = (b.beat == 3'h3 && b.nxt.vld) ||
			b.beat == {len8, 2'h3};
	endfunction: burst_end

	function automatic ddbp_pkg::ddbp_burst_type burst_step(
		input ddbp_pkg::ddbp_burst_type b, input logic len8);
		burst_step = b;
		if (burst_end(b, len8))
		begin
			burst_step.cur = b.nxt;
			burst_step.nxt.vld = 1'b0;
			burst_step.beat = 3'h0;
		end
		else
			burst_step.beat = b.beat + 3'h1;
	endfunction: burst_step

	// A command arriving while a burst runs waits as its follower
	function automatic ddbp_pkg::ddbp_burst_type burst_arm(
		input ddbp_pkg::ddbp_burst_type b, input ddbp_pkg::ddbp_entry_type e);
		burst_arm = b;
		if (!b.cur.vld)
		begin
			burst_arm.cur = e;
			burst_arm.beat = 3'h0;
		end
		else
			burst_arm.nxt = e;
	endfunction: burst_arm

	function automatic logic [31:0] reg_read(input ddbp_state_type s,
		input logic [7:0] a);
		reg_read = 32'h0000_0000;
		unique case (a)
			`DDBP_MODE_OFS:
				reg_read = {25'h0, s.cl, s.bt, s.bl};
			`DDBP_EXT_OFS:
				reg_read = {26'h0, s.al, 3'h0};
			`DDBP_STAT_OFS:
				reg_read = {8'h00, s.wr_cnt, s.rd_cnt, 6'h00, s.wb.cur.vld,
					s.rd_state != ddbp_pkg::ddbp_rd_idle};
			default:
				reg_read = 32'h0000_0000;
		endcase
	endfunction: reg_read

	assign pins_raw = {mem_ck, cs_n, ras_n, cas_n, we_n, bank, col_addr,
		dq_in, dqs_in, write_byte_mask};

	always_comb
	begin
		next_st = st;
		next_st.s1 = pins_raw;
		next_st.s2 = st.s1;
		next_st.ck3 = st.s2.ck;
		next_st.dqs3 = st.s2.dqs;
		rise = st.s2.ck && !st.ck3;
		fall = !st.s2.ck && st.ck3;
		bl8 = st.bl == `DDBP_BL8;
		rl = {1'b0, st.al} + {1'b0, st.cl};

		// Register bus, zero wait states, read data fetched in address phase
		next_st.hreadyout = 1'b1;
		next_st.hresp = 1'b0;
		next_st.ah_wr = 1'b0;
		if (st.ah_wr)
		begin
			unique case (st.ah_addr)
				`DDBP_MODE_OFS:
				begin
					if (hwdata[`DDBP_BL_F] == `DDBP_BL4 ||
						hwdata[`DDBP_BL_F] == `DDBP_BL8)
						next_st.bl = hwdata[`DDBP_BL_F];
					next_st.bt = hwdata[`DDBP_BT_F];
					if (hwdata[`DDBP_CL_F] >= `DDBP_CL_MIN)
						next_st.cl = hwdata[`DDBP_CL_F];
				end
				`DDBP_EXT_OFS:
					next_st.al = hwdata[`DDBP_AL_F];
				default:
				begin
				end
			endcase
		end
		if (hsel && hready && htrans[1])
		begin
			next_st.ah_wr = hwrite;
			next_st.ah_addr = haddr[7:0];
			if (!hwrite)
				next_st.hrdata = reg_read(st, haddr[7:0]);
		end

		// Only read and write are decoded; only a following command of the same kind (read after read, write after write) can cut a burst short
		cmd_rd = !st.s2.cs_n && st.s2.ras_n && !st.s2.cas_n &&
			st.s2.we_n;
		cmd_wr = !st.s2.cs_n && st.s2.ras_n && !st.s2.cas_n &&
			!st.s2.we_n;
		cmd_e = {1'b1, st.s2.bank, st.s2.col};
		rd_arm = rise && st.pipe_rd[rl - `DDBP_RD_LEAD];
		wr_arm = rise && st.pipe_wr[rl - `DDBP_WR_LEAD];
		if (rise)
		begin
			next_st.pipe_rd = {st.pipe_rd[PIPE_DEPTH-2:0], cmd_rd};
			next_st.pipe_wr = {st.pipe_wr[PIPE_DEPTH-2:0], cmd_wr};
			next_st.pipe_e = {st.pipe_e[PIPE_DEPTH-2:0], cmd_e};
		end

		// Write capture: rising strobe for even beats, falling for odd
		wcap = st.wb.cur.vld && (st.s2.dqs != st.dqs3) &&
			(st.s2.dqs ^ st.wb.beat[0]);
		m.wr_en = wcap;
		m.wr_bank = st.wb.cur.bank;
		m.wr_col = {st.wb.cur.col[9:3], wr_low};
		m.wr_data = st.s2.dq;
		m.wr_keep = ~st.s2.mask;
		if (wcap)
		begin
			if (burst_end(st.wb, bl8))
				next_st.wr_cnt = st.wr_cnt + 8'h01;
			next_st.wb = burst_step(st.wb, bl8);
		end
		if (wr_arm)
			next_st.wb = burst_arm(next_st.wb, st.pipe_e[rl - `DDBP_WR_LEAD]);

		// Read output; the mask pins take no part here
		m.rd_bank = st.rb.cur.bank;
		m.rd_col = {st.rb.cur.col[9:3], rd_low};
		emit = st.rb.cur.vld && ((rise && !st.rb.beat[0]) ||
			(fall && st.rb.beat[0]));
		unique case (st.rd_state)
			ddbp_pkg::ddbp_rd_idle:
			begin
			end
			ddbp_pkg::ddbp_rd_pre, ddbp_pkg::ddbp_rd_data:
			begin
				if (emit && (st.rd_state == ddbp_pkg::ddbp_rd_data || rise))
				begin
					next_st.dq_out = m.rd_data;
					next_st.dq_oe_n = 1'b0;
					next_st.dqs_out = rise;
					if (burst_end(st.rb, bl8))
						next_st.rd_cnt = st.rd_cnt + 8'h01;
					next_st.rb = burst_step(st.rb, bl8);
					next_st.rd_state = next_st.rb.cur.vld ?
						ddbp_pkg::ddbp_rd_data : ddbp_pkg::ddbp_rd_post;
				end
			end
			ddbp_pkg::ddbp_rd_post:
			begin
				// Strobe stays low for half a clock after the last beat
				if (rise)
				begin
					next_st.rd_state = ddbp_pkg::ddbp_rd_idle;
					next_st.dq_oe_n = 1'b1;
					next_st.dqs_oe_n = 1'b1;
				end
			end
		endcase
		if (rd_arm)
		begin
			next_st.rb = burst_arm(next_st.rb, st.pipe_e[rl - `DDBP_RD_LEAD]);
			if (st.rd_state == ddbp_pkg::ddbp_rd_idle ||
				st.rd_state == ddbp_pkg::ddbp_rd_post)
			begin
				next_st.rd_state = ddbp_pkg::ddbp_rd_pre;
				next_st.dqs_oe_n = 1'b0;
				next_st.dqs_out = 1'b0;
				next_st.dq_oe_n = 1'b1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st <= '0;
			st.bl <= `DDBP_BL_RST;
			st.bt <= `DDBP_BT_RST;
			st.cl <= `DDBP_CL_RST;
			st.al <= `DDBP_AL_RST;
			st.hreadyout <= 1'b1;
			st.dq_oe_n <= 1'b1;
			st.dqs_oe_n <= 1'b1;
		end
		else
			st <= next_st;
	end

	assign hreadyout = st.hreadyout;
	assign hrdata = st.hrdata;
	assign hresp = st.hresp;
	assign dq_out = st.dq_out;
	assign dq_oe_n = st.dq_oe_n;
	assign dqs_out = st.dqs_out;
	assign dqs_oe_n = st.dqs_oe_n;

	default clocking ddbp_cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	bl_legal_a:
	assert property (st.bl == `DDBP_BL4 || st.bl == `DDBP_BL8)
		else $error("illegal burst length held");
	seq_order_a:
	assert property (m.wr_en && !st.bt |-> m.wr_col[1:0] ==
		st.wb.cur.col[1:0] + st.wb.beat[1:0] &&
		m.wr_col[2] == (st.wb.cur.col[2] ^ st.wb.beat[2]))
		else $error("sequential column order wrong");
	xor_order_a:
	assert property (m.wr_en && st.bt |->
		m.wr_col[2:0] == (st.wb.cur.col[2:0] ^ st.wb.beat))
		else $error("interleaved column order wrong");
	read_start_a:
	assert property (rd_arm && st.rd_state == ddbp_pkg::ddbp_rd_idle |=>
		st.rd_state == ddbp_pkg::ddbp_rd_pre ##[1:16]
		(st.rd_state == ddbp_pkg::ddbp_rd_data && !st.dq_oe_n))
		else $error("read data did not follow preamble");
	pre_low_a:
	assert property (st.rd_state == ddbp_pkg::ddbp_rd_pre |->
		!st.dqs_oe_n && !st.dqs_out && st.dq_oe_n)
		else $error("preamble strobe not driven low");
	first_rise_a:
	assert property (st.rd_state == ddbp_pkg::ddbp_rd_pre && rise |=>
		st.dqs_out && !st.dq_oe_n && $rose(st.dqs_out))
		else $error("first read beat not on rising strobe");
	wr_lat_a:
	assert property (wr_arm |=> st.wb.cur.vld)
		else $error("write burst not armed at write latency");
	wr_stop_a:
	assert property (m.wr_en && st.wb.beat == {bl8, 2'h3} &&
		!st.wb.nxt.vld |=> !st.wb.cur.vld [*2])
		else $error("write capture did not stop at burst end");
	rd_nomask_a:
	assert property (st.rd_state != ddbp_pkg::ddbp_rd_idle &&
		!st.wb.cur.vld |-> !m.wr_en)
		else $error("array written during read");
	rd_done_c: cover property (st.rd_state == ddbp_pkg::ddbp_rd_post);
	wr_done_c: cover property (wcap && burst_end(st.wb, bl8));
	wr_cut_c: cover property (wcap && st.wb.beat == 3'h3 && st.wb.nxt.vld);
	rd_cut_c: cover property (emit && st.rb.beat == 3'h3 && st.rb.nxt.vld);
endmodule: ddbp_top

// ### tb/ddbp_ctrl_model.sv
// Memory controller model: commands, strobed write data, read capture
`timescale 1ns/100ps
module ddbp_ctrl_model (
	// Device side
	input logic hclk,
	input logic [15:0] dq_out,
	input logic dq_oe_n,
	input logic dqs_out,
	input logic dqs_oe_n,
	// Controller pins
	output logic mem_ck,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [1:0] bank,
	output logic [9:0] col_addr,
	output logic [15:0] dq,
	output logic dqs,
	output logic [1:0] write_byte_mask
);
	logic [15:0] got [$];
	int ncyc = 0;
	int t0, pre, first;
	logic prev_s, prev_oe;
	initial
	begin
		{mem_ck, cs_n, ras_n, cas_n, we_n} = 5'h0F;
		{bank, col_addr, dq, dqs, write_byte_mask} = 31'h0;
	end
	// Clock runs only inside frames
	task automatic ck_cyc();
		#40 mem_ck = 1'b1;
		#40 mem_ck = 1'b0;
	endtask: ck_cyc
	// Only plain reads and writes: no stop, precharge or auto-precharge
	task automatic cmd(input logic w, input logic [1:0] b, input logic [9:0] c);
		{cs_n, ras_n, cas_n, we_n} = {3'b010, !w};
		bank = b;
		col_addr = c;
		#40 mem_ck = 1'b1;
		t0 = ncyc;
		#40 mem_ck = 1'b0;
		cs_n = 1'b1;
		col_addr = ~c;
	endtask: cmd
	task automatic wr(input logic [1:0] b, input logic [9:0] c, input int wl,
		input logic [15:0] d [8], input logic [1:0] m [8]);
		@(posedge hclk);
		#3 cmd(1'b1, b, c);
		repeat (wl - 1) ck_cyc();
		dqs = 1'b0;
		// Ninth beat is extra and must be dropped
		for (int k = 0; k < 9; k++)
		begin
			#20 dq = (k < 8) ? d[k] : ~d[7];
			write_byte_mask = (k < 8) ? m[k] : 2'h0;
			#20 mem_ck = ~mem_ck;
			dqs = ~dqs;
		end
		#20 dq = ~dq;
		dqs = ~dqs;
		#20 mem_ck = 1'b0;
		repeat (3) ck_cyc();
	endtask: wr
	task automatic rd(input logic [1:0] b, input logic [9:0] c,
		input logic [9:0] c2, input logic two, input int rl);
		got.delete();
		@(posedge hclk);
		#3 cmd(1'b0, b, c);
		if (two)
		begin
			ck_cyc();
			cmd(1'b0, b, c2);
		end
		repeat (rl + 8)
		begin
			write_byte_mask = 2'($urandom);
			ck_cyc();
		end
	endtask: rd
	always @(negedge hclk)
	begin
		ncyc <= ncyc + 1;
		prev_s <= dqs_out;
		prev_oe <= dqs_oe_n;
		if (dqs_oe_n === 1'b0 && prev_oe === 1'b1)
			pre <= ncyc;
		if (dq_oe_n === 1'b0 && dqs_out !== prev_s)
		begin
			if (got.size() == 0)
				first <= ncyc;
			got.push_back(dq_out);
		end
	end
endmodule: ddbp_ctrl_model

// ### tb/test_ddr2_burst_data_path.sv
// Self-checking bench of the burst data path
`timescale 1ns/100ps
module test_ddr2_burst_data_path;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b1;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp, dq_oe_n, dqs_out, dqs_oe_n, pm_dqs;
	logic mem_ck, cs_n, ras_n, cas_n, we_n;
	logic [31:0] hrdata;
	logic [15:0] dq_out, pm_dq;
	logic [1:0] bank, write_byte_mask;
	logic [9:0] col_addr;
	int fail_count = 0;
	int tests_run = 0;
	int cyc = 0;
	always #5 hclk = ~hclk;
	ddbp_top #(.PIPE_DEPTH(16)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
		.hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout,
		.hrdata, .hresp, .mem_ck, .cs_n, .ras_n, .cas_n, .we_n, .bank,
		.col_addr, .dq_in(dq_oe_n ? pm_dq : dq_out), .dq_out, .dq_oe_n,
		.dqs_in(dqs_oe_n ? pm_dqs : dqs_out), .dqs_out, .dqs_oe_n,
		.write_byte_mask);
	ddbp_ctrl_model pm (.hclk, .dq_out, .dq_oe_n, .dqs_out, .dqs_oe_n, .mem_ck,
		.cs_n, .ras_n, .cas_n, .we_n, .bank, .col_addr, .dq(pm_dq),
		.dqs(pm_dqs), .write_byte_mask);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask: chk
	task automatic final_report();
		if (fail_count == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask: final_report
	// Idle edge first so a read never follows a write back to back
	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask: ahb
	function automatic logic [2:0] ord(input logic [2:0] s,
		input logic [2:0] k, input logic l8, input logic il);
		if (il)
			return l8 ? s ^ k : {s[2], s[1:0] ^ k[1:0]};
		return {l8 ? s[2] ^ k[2] : s[2], 2'(s[1:0] + k[1:0])};
	endfunction: ord
	always @(posedge hclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			fail_count++;
			final_report();
		end
	end
	initial
	begin
		logic [31:0] r;
		logic [15:0] d [8], e [8];
		logic [1:0] m [8];
		logic [2:0] cl, al, s, s2;
		logic [1:0] b;
		logic [9:0] g;
		logic l8, il, two;
		int rl, nrd, nwr, k;
		r = $urandom(32'hC66BB852);
		nrd = 0;
		nwr = 0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'b0, 8'h00, 32'h0, r);
		chk(r, 32'h00000032);
		ahb(1'b1, 8'h00, 32'h0000001D, r);
		ahb(1'b0, 8'h00, 32'h0, r);
		chk(r, 32'h0000003A);
		ahb(1'b1, 8'h0C, 32'hFFFFFFFF, r);
		ahb(1'b0, 8'h0C, 32'h0, r);
		chk(r, 32'h0);
		for (int i = 0; i < 8; i++)
		begin
			cl = 3'($urandom_range(5, 3));
			al = 3'($urandom_range(3, 0));
			rl = int'(cl) + int'(al);
			b = 2'($urandom);
			g = {7'($urandom), 3'h0};
			l8 = i[1];
			il = i[0];
			two = l8 && i >= 4;
			ahb(1'b1, 8'h04, {26'h0, al, 3'h0}, r);
			// Writes start at column zero of the group, so both orders
			// store beat k at column k and the interleaved write check runs
			ahb(1'b1, 8'h00, {25'h0, cl, il, 3'h3}, r);
			for (k = 0; k < 8; k++)
			begin
				e[k] = 16'($urandom);
				m[k] = 2'h0;
			end
			pm.wr(b, g, rl - 1, e, m);
			for (k = 0; k < 8; k++)
			begin
				d[k] = 16'($urandom);
				m[k] = 2'($urandom);
				e[k][15:8] = m[k][1] ? e[k][15:8] : d[k][15:8];
				e[k][7:0] = m[k][0] ? e[k][7:0] : d[k][7:0];
			end
			pm.wr(b, g, rl - 1, d, m);
			nwr += 2;
			ahb(1'b1, 8'h00, {25'h0, cl, il, l8 ? 3'h3 : 3'h2}, r);
			s = 3'($urandom);
			s2 = 3'($urandom);
			pm.rd(b, g | 10'(s), g | 10'(s2), two, rl);
			nrd += two ? 2 : 1;
			chk(32'(pm.got.size()), two ? 12 : l8 ? 8 : 4);
			for (k = 0; k < pm.got.size(); k++)
				chk(pm.got[k], e[(two && k >= 4) ? ord(s2, 3'(k - 4), 1'b1, il) :
					ord(s, 3'(k), l8, il)]);
			if (!two)
			begin
				chk((pm.first - pm.t0) / 8, rl);
				chk(pm.first - pm.pre, 8);
			end
		end
		ahb(1'b0, 8'h08, 32'h0, r);
		chk(r, {8'h0, 8'(nwr), 8'(nrd), 8'h0});
		final_report();
	end
endmodule: test_ddr2_burst_data_path
